/* logic/uec_pkg.sv */
// shared constants and types of the usb endpoint control block
package uec_pkg;

  // endpoint count and index width
  localparam int          EP_COUNT     = 16;
  localparam int          EP_IDX_W     = 4;
  localparam int          EP_DATA_W    = 8;

  // register map, byte addresses on the register bus
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFF_EP_BASE  = 8'h00;
  localparam logic [7:0]  OFF_EP_LAST  = 8'h3C;
  localparam logic [7:0]  OFF_STATUS   = 8'h40;
  localparam logic [7:0]  OFF_MASK     = 8'h44;

  // endpoint control field positions
  localparam int          BIT_LSD      = 7;
  localparam int          BIT_RETRYOFF = 6;
  localparam int          BIT_CTRL_DIS = 4;
  localparam int          BIT_RX_EN    = 3;
  localparam int          BIT_TX_EN    = 2;
  localparam int          BIT_STALLED  = 1;
  localparam int          BIT_HSHK     = 0;

  // bits held in the control memory (bit 5 absent, bit 1 kept apart)
  localparam logic [7:0]  EP_MEM_MASK  = 8'hDD;
  localparam logic [7:0]  EP_RESET     = 8'h00;

  // event status bits
  localparam int          EV_W         = 3;
  localparam int          EV_REFUSED   = 0;
  localparam int          EV_STALL     = 1;
  localparam int          EV_SETUP     = 2;
  localparam logic [2:0]  EV_RESET     = 3'h0;

  // bus responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [31:0] DATA_ZERO    = 32'h0000_0000;

  // token kind seen by the protocol engine
  typedef enum logic [2:0] {
    PID_OUT   = 3'b001,
    PID_IN    = 3'b010,
    PID_SETUP = 3'b100
  } uec_pid_t;

  // read channel states
  typedef enum logic [2:0] {
    RD_IDLE  = 3'b001,
    RD_FETCH = 3'b010,
    RD_RESP  = 3'b100
  } uec_rd_state_t;

  // token offered by the protocol engine
  typedef struct packed {
    logic [3:0] ep;
    uec_pid_t   pid;
  } uec_token_t;

  // verdict handed back to the protocol engine
  typedef struct packed {
    logic accept;
    logic handshake;
    logic stall;
    logic setup_ok;
    logic low_speed_direct;
    logic nak_retry_disable;
  } uec_answer_t;

endpackage

/* logic/uec_ep_mem.sv */
// endpoint control memory with one write and two registered read ports
`timescale 1ns/100ps
module uec_ep_mem
  import uec_pkg::*;
#(
  parameter int DEPTH = EP_COUNT,
  parameter int WIDTH = EP_DATA_W,
  parameter int AW    = EP_IDX_W
)
(
  // clock and synchronous reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // read port a
  input  wire logic [AW-1:0]    raddr_a,
  output logic      [WIDTH-1:0] rdata_a,
  // read port b
  input  wire logic [AW-1:0]    raddr_b,
  output logic      [WIDTH-1:0] rdata_b
);

  logic [WIDTH-1:0] mem_r [DEPTH];  // storage words

  // storage: all words clear on reset, one word written per cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= WIDTH'(EP_RESET);
    end
    else if (we)
    begin
      mem_r[waddr] <= wdata;
    end
  end

  // registered reads; a read in the write cycle returns the old word
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rdata_a <= '0;
      rdata_b <= '0;
    end
    else
    begin
      rdata_a <= mem_r[raddr_a];
      rdata_b <= mem_r[raddr_b];
    end
  end

endmodule

/* logic/uec_endpoint_ctrl.sv */
// usb endpoint control registers, token gating and axi4-lite slave
`timescale 1ns/100ps
// What this block does
// - sixteen identical endpoint control registers, one layout
// - bits 31-8 and bit 5 read zero
// - implemented bits read/write, zero after reset
// - endpoint zero host: direct low-speed, else preamble
// - endpoint zero host: bit 6 stops nak retries
// - both directions on: bit 4 refuses setup
// - bit 4 ignored unless both directions on
// - bit 3 enables receive direction
// - bit 2 enables transmit direction
// - bit 1 reports endpoint stalled
// - bit 0 enables handshake packets
module uec_endpoint_ctrl
  import uec_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  // axi4-lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // axi4-lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  // axi4-lite read data
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // token lookup from the protocol engine
  input  wire logic              tok_valid,
  input  wire uec_token_t        tok,
  input  wire logic              host_mode,
  // hardware stall report from the protocol engine
  input  wire logic              stall_set_valid,
  input  wire logic [3:0]        stall_set_ep,
  // verdict to the protocol engine
  output logic                   ans_valid,
  output uec_answer_t            ans,
  // endpoint zero host-mode levels
  output logic                   ep0_low_speed_direct,
  output logic                   ep0_nak_retry_disable,
  // interrupt
  output logic                   irq
);

  // true when the address hits one of the endpoint words
  function automatic logic is_ep_addr(input logic [ADDR_W-1:0] a);
    is_ep_addr = (a[1:0] == 2'h0) && (a <= OFF_EP_LAST);
  endfunction

  // true when the address hits any mapped word
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = is_ep_addr(a) || (a == OFF_STATUS) || (a == OFF_MASK);
  endfunction

  // endpoint number carried by an endpoint word address
  function automatic logic [3:0] ep_of(input logic [ADDR_W-1:0] a);
    ep_of = a[5:2];
  endfunction

  // write channel state
  logic                  awready_r;    // address slot free
  logic                  aw_have_r;    // address held
  logic [ADDR_W-1:0]     awaddr_r;     // held address
  logic                  wready_r;     // data slot free
  logic                  w_have_r;     // data held
  logic [31:0]           wdata_r;      // held data
  logic                  wlane_r;      // byte lane zero strobe
  logic                  bvalid_r;     // response pending
  logic [1:0]            bresp_r;      // response code
  logic                  wr_fire;      // write takes effect now
  logic                  wr_ep;        // write hits an endpoint word

  // read channel state
  uec_rd_state_t         rd_state_r;   // read phase
  uec_rd_state_t         rd_state_nxt; // next read phase
  logic                  arready_r;    // read address slot free
  logic [ADDR_W-1:0]     araddr_r;     // held read address
  logic [31:0]           rdata_r;      // read data
  logic [1:0]            rresp_r;      // read response code
  logic                  rvalid_r;     // read data valid

  // endpoint state
  logic [EP_COUNT-1:0]   stall_r;      // stall status per endpoint
  logic [EP_COUNT-1:0]   stall_nxt;    // stall status next
  logic [7:0]            mem_bus_q;    // control word for the bus
  logic [7:0]            mem_tok_q;    // control word for the token
  logic                  ep0_lsd_r;    // endpoint zero bit 7 copy
  logic                  ep0_rdis_r;   // endpoint zero bit 6 copy

  // token pipeline
  logic                  tok_stage_r;  // token awaiting its verdict
  uec_token_t            tok_r;        // token under lookup
  logic                  host_r;       // host mode at token time
  logic                  ans_valid_r;  // verdict valid
  uec_answer_t           ans_r;        // verdict
  uec_answer_t           ans_nxt;      // verdict being formed
  logic                  dir_ok;       // direction enabled for token

  // interrupt state
  logic [EV_W-1:0]       status_r;     // sticky events
  logic [EV_W-1:0]       status_nxt;   // sticky events next
  logic [EV_W-1:0]       mask_r;       // event mask
  logic [EV_W-1:0]       mask_nxt;     // event mask next
  logic [EV_W-1:0]       ev_set;       // events raised this cycle
  logic                  irq_r;        // interrupt level

  // outputs come straight from flops
  assign awready               = awready_r;
  assign wready                = wready_r;
  assign bvalid                = bvalid_r;
  assign bresp                 = bresp_r;
  assign arready               = arready_r;
  assign rdata                 = rdata_r;
  assign rresp                 = rresp_r;
  assign rvalid                = rvalid_r;
  assign ans_valid             = ans_valid_r;
  assign ans                   = ans_r;
  assign ep0_low_speed_direct  = ep0_lsd_r;
  assign ep0_nak_retry_disable = ep0_rdis_r;
  assign irq                   = irq_r;

  // a write lands once address and data are both held
  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
  assign wr_ep   = is_ep_addr(awaddr_r);

  // control memory, one word per endpoint
  uec_ep_mem #(
    .DEPTH (EP_COUNT),
    .WIDTH (EP_DATA_W),
    .AW    (EP_IDX_W)
  ) u_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (wr_fire && wr_ep && wlane_r),
    .waddr   (ep_of(awaddr_r)),
    .wdata   (wdata_r[7:0] & EP_MEM_MASK),  // bit 5 stays zero
    .raddr_a (ep_of(araddr)),
    .rdata_a (mem_bus_q),
    .raddr_b (tok.ep),
    .rdata_b (mem_tok_q)
  );

  // write address slot: taken once, freed by the response handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b1;
      aw_have_r <= 1'b0;
      awaddr_r  <= '0;
    end
    else if (awvalid && awready_r)
    begin
      awready_r <= 1'b0;
      aw_have_r <= 1'b1;
      awaddr_r  <= awaddr;
    end
    else if (bvalid_r && bready)
    begin
      awready_r <= 1'b1;
      aw_have_r <= 1'b0;
    end
  end

  // write data slot: independent of the address, same release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_r <= 1'b1;
      w_have_r <= 1'b0;
      wdata_r  <= DATA_ZERO;
      wlane_r  <= 1'b0;
    end
    else if (wvalid && wready_r)
    begin
      wready_r <= 1'b0;
      w_have_r <= 1'b1;
      wdata_r  <= wdata;
      wlane_r  <= wstrb[0];  // only lane zero holds implemented bits
    end
    else if (bvalid_r && bready)
    begin
      wready_r <= 1'b1;
      w_have_r <= 1'b0;
    end
  end

  // write response: error for unmapped words
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= is_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
    begin
      bvalid_r <= 1'b0;
    end
  end

  // endpoint zero host controls mirrored for the host engine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ep0_lsd_r  <= 1'b0;
      ep0_rdis_r <= 1'b0;
    end
    else if (wr_fire && wlane_r && awaddr_r == OFF_EP_BASE)
    begin
      ep0_lsd_r  <= wdata_r[BIT_LSD];
      ep0_rdis_r <= wdata_r[BIT_RETRYOFF];
    end
  end

  // stall status: software writes either value, hardware report wins
  always_comb
  begin
    stall_nxt = stall_r;
    if (wr_fire && wr_ep && wlane_r)
      stall_nxt[ep_of(awaddr_r)] = wdata_r[BIT_STALLED];
    if (stall_set_valid)
      stall_nxt[stall_set_ep] = 1'b1;
  end

  // stall status register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stall_r <= '0;
    else
      stall_r <= stall_nxt;
  end

  // read phase sequencing
  always_comb
  begin
    rd_state_nxt = rd_state_r;
    unique case (rd_state_r)
      RD_IDLE:  if (arvalid) rd_state_nxt = RD_FETCH;
      RD_FETCH: rd_state_nxt = RD_RESP;
      RD_RESP:  if (rready) rd_state_nxt = RD_IDLE;
    endcase
  end

  // read state and address slot
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_r <= RD_IDLE;
      arready_r  <= 1'b1;
      araddr_r   <= '0;
    end
    else
    begin
      rd_state_r <= rd_state_nxt;
      arready_r  <= (rd_state_nxt == RD_IDLE);
      if (arvalid && arready_r)
        araddr_r <= araddr;
    end
  end

  // read data: formed once the memory word is out
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= DATA_ZERO;
      rresp_r  <= RESP_OKAY;
    end
    else if (rd_state_r == RD_FETCH)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= is_mapped(araddr_r) ? RESP_OKAY : RESP_SLVERR;
      rdata_r  <= DATA_ZERO;  // upper bits read zero
      if (is_ep_addr(araddr_r))
      begin
        rdata_r[7:0] <= mem_bus_q;
        rdata_r[BIT_STALLED] <= stall_r[ep_of(araddr_r)];
      end
      else if (araddr_r == OFF_STATUS)
        rdata_r[EV_W-1:0] <= status_r;
      else if (araddr_r == OFF_MASK)
        rdata_r[EV_W-1:0] <= mask_r;
    end
    else if (rvalid_r && rready)
    begin
      rvalid_r <= 1'b0;
    end
  end

  // token stage one: hold the token while its word is read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tok_stage_r <= 1'b0;
      tok_r       <= '{ep: 4'h0, pid: PID_OUT};
      host_r      <= 1'b0;
    end
    else
    begin
      tok_stage_r <= tok_valid;
      if (tok_valid)
      begin
        tok_r  <= tok;
        host_r <= host_mode;
      end
    end
  end

  // direction check of the token against the endpoint enables
  always_comb
  begin
    unique case (tok_r.pid)
      PID_OUT:   dir_ok = mem_tok_q[BIT_RX_EN];
      PID_IN:    dir_ok = mem_tok_q[BIT_TX_EN];
      // bit 4 only counts with both directions on
      PID_SETUP: dir_ok = mem_tok_q[BIT_RX_EN] &&
                          !(mem_tok_q[BIT_TX_EN] &&
                            mem_tok_q[BIT_CTRL_DIS]);
      default:   dir_ok = 1'b0;  // malformed token kind is refused
    endcase
  end

  // verdict for the held token
  always_comb
  begin
    ans_nxt           = '0;
    ans_nxt.accept    = dir_ok;
    ans_nxt.stall     = dir_ok && stall_r[tok_r.ep];
    ans_nxt.handshake = dir_ok && mem_tok_q[BIT_HSHK];
    ans_nxt.setup_ok  = dir_ok && (tok_r.pid == PID_SETUP);
    if (host_r && tok_r.ep == 4'h0)
    begin
      ans_nxt.low_speed_direct  = mem_tok_q[BIT_LSD];
      ans_nxt.nak_retry_disable = mem_tok_q[BIT_RETRYOFF];
    end
  end

  // token stage two: registered verdict
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ans_valid_r <= 1'b0;
      ans_r       <= '0;
    end
    else
    begin
      ans_valid_r <= tok_stage_r;
      if (tok_stage_r)
        ans_r <= ans_nxt;
    end
  end

  // events from the verdict
  always_comb
  begin
    ev_set             = '0;
    ev_set[EV_REFUSED] = tok_stage_r && !ans_nxt.accept;
    ev_set[EV_STALL]   = tok_stage_r && ans_nxt.stall;
    ev_set[EV_SETUP]   = tok_stage_r && ans_nxt.setup_ok;
  end

  // sticky status and mask; a new event wins over a clearing write
  always_comb
  begin
    status_nxt = status_r;
    mask_nxt   = mask_r;
    if (wr_fire && wlane_r && awaddr_r == OFF_STATUS)
      status_nxt = status_r & ~wdata_r[EV_W-1:0];
    if (wr_fire && wlane_r && awaddr_r == OFF_MASK)
      mask_nxt = wdata_r[EV_W-1:0];
    status_nxt = status_nxt | ev_set;
  end

  // interrupt registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_r <= EV_RESET;
      mask_r   <= EV_RESET;
      irq_r    <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      irq_r    <= |(status_nxt & mask_nxt);
    end
  end

endmodule

/* bench/uec_endpoint_ctrl_props.sv */
// concurrent checks on the endpoint control block ports
`timescale 1ns/100ps
module uec_endpoint_ctrl_props
  import uec_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus handshakes
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // token side
  input wire logic        tok_valid,
  input wire uec_token_t  tok,
  input wire logic        host_mode,
  input wire logic        ans_valid,
  input wire uec_answer_t ans,
  input wire logic        irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // every token gets its verdict two edges later
  AST_ANS_AFTER: assert property (tok_valid |-> ##2 ans_valid)
    else $error("verdict missing after token");
  AST_ANS_CAUSE: assert property (ans_valid |-> $past(tok_valid, 2))
    else $error("verdict without token");
  // a refused token carries no handshake, stall or setup flag
  AST_NOACC_QUIET: assert property (ans_valid && !ans.accept
    |-> !(ans.handshake || ans.stall || ans.setup_ok))
    else $error("refused token flagged");
  AST_SETUP_PID: assert property (ans_valid && ans.setup_ok
    |-> $past(tok.pid, 2) == PID_SETUP)
    else $error("setup flag on other token");
  // host fields only for endpoint zero in host mode
  AST_HOST_EP0: assert property (ans_valid && (ans.low_speed_direct
    || ans.nak_retry_disable) |-> $past(host_mode, 2)
    && $past(tok.ep, 2) == 4'h0)
    else $error("host field outside endpoint zero");
  AST_B_LAT: assert property (awvalid && awready && wvalid && wready
    |-> ##2 bvalid)
    else $error("write response late");
  AST_R_LAT: assert property (arvalid && arready |-> ##2 rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (rvalid && !rready
    |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_R_ZERO: assert property (rvalid |-> rdata[31:8] == 24'h00_0000
    && !rdata[5])
    else $error("unimplemented bits nonzero");

  // main scenarios reached
  cover property (ans_valid && ans.setup_ok);
  cover property (ans_valid && !ans.accept);
  cover property (irq);
endmodule

bind uec_endpoint_ctrl uec_endpoint_ctrl_props u_props (.*);

/* bench/uec_usb_peer.sv */
// behavioural usb peer: offers tokens and stall reports to the block
`timescale 1ns/100ps
module uec_usb_peer
  import uec_pkg::*;
(
  // clock
  input  wire logic  aclk,
  // token offer
  output logic       tok_valid,
  output uec_token_t tok,
  output logic       host_mode,
  // stall report
  output logic       stall_set_valid,
  output logic [3:0] stall_set_ep
);
  initial
  begin
    tok_valid = 1'b0;
    tok = 7'h00;
    host_mode = 1'b0;
    stall_set_valid = 1'b0;
    stall_set_ep = 4'h0;
  end

  // one token for one cycle, then the bus shows no stale token
  task automatic send(input logic [3:0] ep, input uec_pid_t pid,
                      input logic hm);
    begin
      tok_valid <= 1'b1;
      tok <= {ep, pid};
      host_mode <= hm;
      @(posedge aclk);
      tok_valid <= 1'b0;
      tok <= ~{ep, pid};
    end
  endtask

  // endpoint answered with stall, reported for one cycle
  task automatic stall(input logic [3:0] ep);
    begin
      stall_set_valid <= 1'b1;
      stall_set_ep <= ep;
      @(posedge aclk);
      stall_set_valid <= 1'b0;
      stall_set_ep <= ~ep;
    end
  endtask
endmodule

/* bench/uec_endpoint_ctrl_tb_top.sv */
// self-checking bench of the endpoint control block
`timescale 1ns/100ps
module uec_endpoint_ctrl_tb_top;
  import uec_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tok_valid, host_mode;
  logic stall_set_valid, ans_valid, lsd, nrd, irq;
  logic [1:0] bresp, rresp;
  logic [3:0] stall_set_ep;
  uec_token_t tok;
  uec_answer_t ans;
  int mismatches = 0, comparisons = 0;

  always #2 aclk = ~aclk;

  uec_endpoint_ctrl u_uec_endpoint_ctrl (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .tok_valid(tok_valid),
    .tok(tok), .host_mode(host_mode), .stall_set_valid(stall_set_valid),
    .stall_set_ep(stall_set_ep), .ans_valid(ans_valid), .ans(ans),
    .ep0_low_speed_direct(lsd), .ep0_nak_retry_disable(nrd), .irq(irq));

  uec_usb_peer u_uec_usb_peer (.aclk(aclk), .tok_valid(tok_valid),
    .tok(tok), .host_mode(host_mode), .stall_set_valid(stall_set_valid),
    .stall_set_ep(stall_set_ep));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bus write; each channel released at the edge it is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);  // one edge between transfers
    cmp(32'(r), 32'(er));
  endtask

  // bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);  // one edge between transfers
    cmp(d, ed);
    cmp(32'(r), 32'(er));
  endtask

  // token through the peer, verdict judged when it appears
  task automatic tk(input logic [3:0] ep, input uec_pid_t p,
                    input logic hm, input logic [5:0] e);
    int n;
    u_uec_usb_peer.send(ep, p, hm);
    n = 0;
    @(negedge aclk);
    while (ans_valid !== 1'b1 && n < 4)
    begin
      @(negedge aclk);
      n++;
    end
    cmp(32'(ans), 32'(e));
    @(posedge aclk);
  endtask

  task automatic t_regs;
    for (int i = 0; i < 16; i++)
    begin
      rd(8'(4 * i), 32'h0000_0000, RESP_OKAY);
      wr(8'(4 * i), 32'hFFFF_FFFF, RESP_OKAY);
      rd(8'(4 * i), 32'h0000_00DF, RESP_OKAY);
      wr(8'(4 * i), 32'h0000_0000, RESP_OKAY);
    end
    wr(8'h48, 32'h0000_0001, RESP_SLVERR);
    rd(8'h48, 32'h0000_0000, RESP_SLVERR);
    $display("test regs done");
  endtask

  // every enable mix against every token kind, host bits set off ep0
  task automatic t_gate;
    uec_pid_t ps[3] = '{PID_OUT, PID_IN, PID_SETUP};
    logic a;
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h0C, {24'h00_0000, 3'h6, i[2:0], 2'h1}, RESP_OKAY);
      for (int k = 0; k < 3; k++)
      begin
        a = ps[k] == PID_OUT ? i[1] : ps[k] == PID_IN ? i[0] :
            i[1] && !(i[0] && i[2]);
        tk(4'h3, ps[k], 1'b1, {a, a, 1'b0, a && k == 2, 2'h0});
      end
    end
    $display("test gate done");
  endtask

  task automatic t_ep0;
    wr(8'h00, 32'h0000_00CD, RESP_OKAY);
    cmp(32'({lsd, nrd}), 32'h0000_0003);
    tk(4'h0, PID_OUT, 1'b1, 6'h33);
    tk(4'h0, PID_OUT, 1'b0, 6'h30);
    wr(8'h00, 32'h0000_004C, RESP_OKAY);
    tk(4'h0, PID_IN, 1'b1, 6'h21);
    $display("test ep0 done");
  endtask

  task automatic t_stall;
    wr(8'h08, 32'h0000_000D, RESP_OKAY);
    u_uec_usb_peer.stall(4'h2);
    rd(8'h08, 32'h0000_000F, RESP_OKAY);
    tk(4'h2, PID_IN, 1'b0, 6'h38);
    wr(8'h08, 32'h0000_000D, RESP_OKAY);
    tk(4'h2, PID_IN, 1'b0, 6'h30);
    $display("test stall done");
  endtask

  task automatic t_irq;
    wr(8'h40, 32'h0000_0007, RESP_OKAY);
    wr(8'h44, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp(32'(irq), 32'h0000_0000);
    tk(4'h5, PID_OUT, 1'b0, 6'h00);
    repeat (2) @(posedge aclk);
    cmp(32'(irq), 32'h0000_0001);
    wr(8'h40, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp(32'(irq), 32'h0000_0000);
    wr(8'h44, 32'h0000_0000, RESP_OKAY);
    tk(4'h5, PID_IN, 1'b0, 6'h00);
    repeat (2) @(posedge aclk);
    cmp(32'(irq), 32'h0000_0000);
    $display("test irq done");
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_gate;
    t_ep0;
    t_stall;
    t_irq;
    stop_test;
  end

  // watchdog far beyond the few hundred cycles of the run
  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    stop_test;
  end
endmodule
